// file: verilog/bwaeh_regs.svh
// Register offsets, field positions, event bits and reset values of the window error handler
`ifndef BWAEH_REGS_SVH
`define BWAEH_REGS_SVH

`define BWAEH_ADR_CSR         8'h00
`define BWAEH_ADR_DAR         8'h04
`define BWAEH_ADR_INT_STAT    8'h08
`define BWAEH_ADR_INT_MASK    8'h0C

`define BWAEH_CSR_ERROR       15
`define BWAEH_CSR_TIMEOUT     14
`define BWAEH_CSR_OPEN        7
`define BWAEH_CSR_WPERMIT     2

`define BWAEH_EV_ACCESS       0
`define BWAEH_EV_TIMEOUT      1
`define BWAEH_EV_POWER_LOW    2
`define BWAEH_EV_WIDTH        3

`define BWAEH_CSR_RESET       16'h0000
`define BWAEH_DAR_RESET       16'h0000
`define BWAEH_INT_RESET       3'h0

`endif

// file: verilog/bwaeh_pkg.sv
// Types shared by the window error handler
package bwaeh_pkg;

	typedef enum logic [1:0] {
		BWAEH_CYC_READ       = 2'b00,
		BWAEH_CYC_READ_PAUSE = 2'b01,
		BWAEH_CYC_WRITE      = 2'b10,
		BWAEH_CYC_WRITE_BYTE = 2'b11
	} bwaeh_cyc_type;

	typedef enum logic [2:0] {
		BWAEH_ST_IDLE   = 3'b000,
		BWAEH_ST_RELAY  = 3'b001,
		BWAEH_ST_ANSWER = 3'b010,
		BWAEH_ST_HANG   = 3'b011,
		BWAEH_ST_IGNORE = 3'b100
	} bwaeh_state_type;

	typedef struct packed {
		logic          valid;
		bwaeh_cyc_type cyc;
		logic [15:0]   addr;
		logic [15:0]   wdata;
	} bwaeh_req_type;

	typedef struct packed {
		logic        valid;
		logic        drive;
		logic [15:0] rdata;
	} bwaeh_resp_type;

endpackage

// file: verilog/bwaeh_sync.sv
// Two-flop synchroniser for levels from the far bus
`timescale 1ns/1ps
module bwaeh_sync (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic [1:0] async_i,
	output logic      [1:0] sync_o
);

	logic [1:0] stage1;
	logic [1:0] stage2;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stage1 <= 2'h0;
			stage2 <= 2'h0;
		end else begin
			stage1 <= async_i;
			stage2 <= stage1;
		end
	end

	assign sync_o = stage2;

endmodule // bwaeh_sync

// file: verilog/bwaeh_top.sv
// Access-error handling of the two-port bus window
// What this block does
// - A failed or illegal window access sets the error flag, control bit 15.
// - A failed write or byte write still returns slave sync; data sits buffered.
// - A failed read or read-pause withholds slave sync; no valid data exists.
// - With error already set, accesses are ignored: no status, sync, or address change.
// - Target-bus timeout or power-low also sets the error flag.
// - Channel closed: any access sets bit 15; sync only for writes.
// - Write permit clear: read-pause errors without sync; writes error with sync.
// - Target timeout sets bits 15 and 14; sync only for writes.
// - Reads through the window from both buses at once set bit 15, no sync.
// - Every access error sets the error flag and may raise the interrupt.
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "bwaeh_regs.svh"
module bwaeh_top (
	input  wire logic                    clk_i,
	input  wire logic                    rst_i,
	input  wire logic                    wb_cyc_i,
	input  wire logic                    wb_stb_i,
	input  wire logic                    wb_we_i,
	input  wire logic [7:0]              wb_adr_i,
	input  wire logic [3:0]              wb_sel_i,
	input  wire logic [31:0]             wb_dat_i,
	output logic      [31:0]             wb_dat_o,
	output logic                         wb_ack_o,
	input  wire bwaeh_pkg::bwaeh_req_type orig_req_i,
	output bwaeh_pkg::bwaeh_resp_type    orig_resp_o,
	output bwaeh_pkg::bwaeh_req_type     tgt_req_o,
	input  wire logic                    tgt_ssyn_i,
	input  wire logic                    tgt_timeout_i,
	input  wire logic [15:0]             tgt_rdata_i,
	input  wire logic                    tgt_power_low_i,
	input  wire logic                    remote_read_i,
	output logic                         irq_o
);

	function automatic logic is_write(input bwaeh_pkg::bwaeh_cyc_type c);
		is_write = (c == bwaeh_pkg::BWAEH_CYC_WRITE) || (c == bwaeh_pkg::BWAEH_CYC_WRITE_BYTE);
	endfunction

	function automatic logic is_read(input bwaeh_pkg::bwaeh_cyc_type c);
		is_read = (c == bwaeh_pkg::BWAEH_CYC_READ) || (c == bwaeh_pkg::BWAEH_CYC_READ_PAUSE);
	endfunction

	// Far-bus levels
	logic [1:0] far_sync;
	logic       power_low;
	logic       remote_read;

	bwaeh_sync u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({remote_read_i, tgt_power_low_i}),
		.sync_o  (far_sync)
	);

	assign power_low   = far_sync[0];
	assign remote_read = far_sync[1];

	// Registers
	logic                          err_flag;
	logic                          tmo_flag;
	logic                          open_bit;
	logic                          wpermit_bit;
	logic [15:0]                   dar;
	logic [`BWAEH_EV_WIDTH-1:0]    int_stat;
	logic [`BWAEH_EV_WIDTH-1:0]    int_mask;
	logic                          next_err_flag;
	logic                          next_tmo_flag;
	logic                          next_open_bit;
	logic                          next_wpermit_bit;
	logic [15:0]                   next_dar;
	logic [`BWAEH_EV_WIDTH-1:0]    next_int_stat;
	logic [`BWAEH_EV_WIDTH-1:0]    next_int_mask;

	// Cycle sequencer
	bwaeh_pkg::bwaeh_state_type    state;
	bwaeh_pkg::bwaeh_state_type    next_state;
	bwaeh_pkg::bwaeh_cyc_type      cyc;
	bwaeh_pkg::bwaeh_cyc_type      next_cyc;
	logic [15:0]                   data_buf;
	logic [15:0]                   next_data_buf;
	logic [15:0]                   rdata;
	logic [15:0]                   next_rdata;
	logic                          tgt_valid;
	logic                          next_tgt_valid;
	logic                          ev_access;
	logic                          ev_timeout;

	// Bus slave
	logic                          ack;
	logic                          next_ack;
	logic [31:0]                   dat;
	logic [31:0]                   next_dat;
	logic                          wb_req;
	logic                          wb_wr;
	logic                          csr_wr;
	logic                          reopen;

	assign wb_req = wb_cyc_i && wb_stb_i && !ack;
	assign wb_wr  = wb_req && wb_we_i;
	assign csr_wr = wb_wr && (wb_adr_i == `BWAEH_ADR_CSR) && wb_sel_i[0];
	assign reopen = csr_wr && wb_dat_i[`BWAEH_CSR_OPEN];

	always_comb begin
		next_state     = state;
		next_cyc       = cyc;
		next_data_buf  = data_buf;
		next_rdata     = rdata;
		next_tgt_valid = tgt_valid;
		next_dar       = dar;
		ev_access      = 1'b0;
		ev_timeout     = 1'b0;
		case (state)
			bwaeh_pkg::BWAEH_ST_IDLE: begin
				if (orig_req_i.valid) begin
					next_cyc      = orig_req_i.cyc;
					next_data_buf = orig_req_i.wdata;
					if (err_flag) begin
						next_state = bwaeh_pkg::BWAEH_ST_IGNORE;
					end else if (!open_bit) begin
						ev_access  = 1'b1;
						next_state = is_write(orig_req_i.cyc) ? bwaeh_pkg::BWAEH_ST_ANSWER
							: bwaeh_pkg::BWAEH_ST_HANG;
					end else if (!wpermit_bit && (orig_req_i.cyc != bwaeh_pkg::BWAEH_CYC_READ)) begin
						ev_access  = 1'b1;
						next_state = is_write(orig_req_i.cyc) ? bwaeh_pkg::BWAEH_ST_ANSWER
							: bwaeh_pkg::BWAEH_ST_HANG;
					end else if (is_read(orig_req_i.cyc) && remote_read) begin
						ev_access  = 1'b1;
						next_state = bwaeh_pkg::BWAEH_ST_HANG;
					end else begin
						next_dar       = orig_req_i.addr;
						next_tgt_valid = 1'b1;
						next_state     = bwaeh_pkg::BWAEH_ST_RELAY;
					end
				end
			end
			bwaeh_pkg::BWAEH_ST_RELAY: begin
				if (tgt_ssyn_i) begin
					next_tgt_valid = 1'b0;
					next_rdata     = tgt_rdata_i;
					next_state     = bwaeh_pkg::BWAEH_ST_ANSWER;
				end else if (tgt_timeout_i) begin
					next_tgt_valid = 1'b0;
					ev_access      = 1'b1;
					ev_timeout     = 1'b1;
					next_state     = is_write(cyc) ? bwaeh_pkg::BWAEH_ST_ANSWER
						: bwaeh_pkg::BWAEH_ST_HANG;
				end
			end
			bwaeh_pkg::BWAEH_ST_ANSWER: begin
				if (!orig_req_i.valid) begin
					next_state = bwaeh_pkg::BWAEH_ST_IDLE;
				end
			end
			bwaeh_pkg::BWAEH_ST_HANG: begin
				if (!orig_req_i.valid) begin
					next_state = bwaeh_pkg::BWAEH_ST_IDLE;
				end
			end
			bwaeh_pkg::BWAEH_ST_IGNORE: begin
				if (!orig_req_i.valid) begin
					next_state = bwaeh_pkg::BWAEH_ST_IDLE;
				end
			end
			default: begin
				next_state     = bwaeh_pkg::BWAEH_ST_IDLE;
				next_tgt_valid = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state     <= bwaeh_pkg::BWAEH_ST_IDLE;
			cyc       <= bwaeh_pkg::BWAEH_CYC_READ;
			data_buf  <= 16'h0000;
			rdata     <= 16'h0000;
			tgt_valid <= 1'b0;
		end else begin
			state     <= next_state;
			cyc       <= next_cyc;
			data_buf  <= next_data_buf;
			rdata     <= next_rdata;
			tgt_valid <= next_tgt_valid;
		end
	end

	// Status, control and interrupt registers
	always_comb begin
		next_err_flag    = err_flag;
		next_tmo_flag    = tmo_flag;
		next_open_bit    = open_bit;
		next_wpermit_bit = wpermit_bit;
		next_int_stat    = int_stat;
		next_int_mask    = int_mask;
		if (reopen) begin
			next_err_flag = 1'b0;
			next_tmo_flag = 1'b0;
		end
		if (csr_wr) begin
			next_open_bit    = wb_dat_i[`BWAEH_CSR_OPEN];
			next_wpermit_bit = wb_dat_i[`BWAEH_CSR_WPERMIT];
		end
		if (wb_wr && (wb_adr_i == `BWAEH_ADR_INT_STAT) && wb_sel_i[0]) begin
			next_int_stat = int_stat & ~wb_dat_i[`BWAEH_EV_WIDTH-1:0];
		end
		if (wb_wr && (wb_adr_i == `BWAEH_ADR_INT_MASK) && wb_sel_i[0]) begin
			next_int_mask = wb_dat_i[`BWAEH_EV_WIDTH-1:0];
		end
		// Hardware sets win over software clears
		if (ev_access || ev_timeout || power_low) begin
			next_err_flag = 1'b1;
		end
		if (ev_timeout) begin
			next_tmo_flag = 1'b1;
		end
		if (ev_access) begin
			next_int_stat[`BWAEH_EV_ACCESS] = 1'b1;
		end
		if (ev_timeout) begin
			next_int_stat[`BWAEH_EV_TIMEOUT] = 1'b1;
		end
		if (power_low) begin
			next_int_stat[`BWAEH_EV_POWER_LOW] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_flag    <= 1'(`BWAEH_CSR_RESET >> `BWAEH_CSR_ERROR);
			tmo_flag    <= 1'b0;
			open_bit    <= 1'b0;
			wpermit_bit <= 1'b0;
			dar         <= `BWAEH_DAR_RESET;
			int_stat    <= `BWAEH_INT_RESET;
			int_mask    <= `BWAEH_INT_RESET;
		end else begin
			err_flag    <= next_err_flag;
			tmo_flag    <= next_tmo_flag;
			open_bit    <= next_open_bit;
			wpermit_bit <= next_wpermit_bit;
			dar         <= next_dar;
			int_stat    <= next_int_stat;
			int_mask    <= next_int_mask;
		end
	end

	// Wishbone answer
	always_comb begin
		next_ack = wb_req;
		next_dat = dat;
		if (wb_req) begin
			next_dat = 32'h00000000;
			case (wb_adr_i)
				`BWAEH_ADR_CSR: begin
					next_dat[`BWAEH_CSR_ERROR]   = err_flag;
					next_dat[`BWAEH_CSR_TIMEOUT] = tmo_flag;
					next_dat[`BWAEH_CSR_OPEN]    = open_bit;
					next_dat[`BWAEH_CSR_WPERMIT] = wpermit_bit;
				end
				`BWAEH_ADR_DAR: begin
					next_dat[15:0] = dar;
				end
				`BWAEH_ADR_INT_STAT: begin
					next_dat[`BWAEH_EV_WIDTH-1:0] = int_stat;
				end
				`BWAEH_ADR_INT_MASK: begin
					next_dat[`BWAEH_EV_WIDTH-1:0] = int_mask;
				end
				default: begin
					next_dat = 32'h00000000;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack <= 1'b0;
			dat <= 32'h00000000;
		end else begin
			ack <= next_ack;
			dat <= next_dat;
		end
	end

	assign wb_ack_o = ack;
	assign wb_dat_o = dat;
	assign irq_o    = |(int_stat & int_mask);

	// Originator answer: sync only in ANSWER, data only for reads
	assign orig_resp_o.valid = (state == bwaeh_pkg::BWAEH_ST_ANSWER);
	assign orig_resp_o.drive = (state == bwaeh_pkg::BWAEH_ST_ANSWER) && is_read(cyc);
	assign orig_resp_o.rdata = rdata;

	// Target-bus request
	assign tgt_req_o.valid = tgt_valid;
	assign tgt_req_o.cyc   = cyc;
	assign tgt_req_o.addr  = dar;
	assign tgt_req_o.wdata = data_buf;

endmodule // bwaeh_top

// file: bench/bwaeh_checker.sv
// Port assertions of the window error handler
`timescale 1ns/1ps
module bwaeh_checker (
	input wire logic                      clk_i,
	input wire logic                      rst_i,
	input wire logic                      wb_cyc_i,
	input wire logic                      wb_stb_i,
	input wire logic                      wb_ack_o,
	input wire bwaeh_pkg::bwaeh_req_type  orig_req_i,
	input wire bwaeh_pkg::bwaeh_resp_type orig_resp_o,
	input wire bwaeh_pkg::bwaeh_req_type  tgt_req_o,
	input wire logic                      tgt_ssyn_i,
	input wire logic                      tgt_timeout_i
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic bus;
	logic tmo;
	assign bus = wb_cyc_i && wb_stb_i;
	assign tmo = tgt_req_o.valid && !tgt_ssyn_i && tgt_timeout_i;
	property p_ack_next; bus && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_ack_idle; !bus |=> !wb_ack_o; endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("ack unasked");
	property p_drive; orig_req_i.valid && orig_resp_o.drive |-> !orig_req_i.cyc[1] && orig_resp_o.valid; endproperty
	a_drive: assert property (p_drive) else $error("data driven wrongly");
	property p_relay; tgt_req_o.valid && tgt_ssyn_i |=> orig_resp_o.valid && !tgt_req_o.valid; endproperty
	a_relay: assert property (p_relay) else $error("relay answer missing");
	property p_tmo_wr; tmo && orig_req_i.cyc[1] |=> orig_resp_o.valid; endproperty
	a_tmo_wr: assert property (p_tmo_wr) else $error("write sync missing");
	property p_tmo_rd; tmo && !orig_req_i.cyc[1] |=> (!orig_resp_o.valid && !orig_resp_o.drive) [*3]; endproperty
	a_tmo_rd: assert property (p_tmo_rd) else $error("read sync given");
	property p_release; !orig_req_i.valid |=> !orig_resp_o.valid && !orig_resp_o.drive; endproperty
	a_release: assert property (p_release) else $error("sync after release");
	property p_tgt_hold; tgt_req_o.valid && !tgt_ssyn_i && !tgt_timeout_i |=> $stable(tgt_req_o); endproperty
	a_tgt_hold: assert property (p_tgt_hold) else $error("target request moved");
	c_read: cover property (tgt_req_o.valid && tgt_ssyn_i && !orig_req_i.cyc[1]);
	c_tmo: cover property (tmo);
	c_ack: cover property (bus && wb_ack_o);
endmodule // bwaeh_checker

bind bwaeh_top bwaeh_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o), .orig_req_i(orig_req_i), .orig_resp_o(orig_resp_o), .tgt_req_o(tgt_req_o),
	.tgt_ssyn_i(tgt_ssyn_i), .tgt_timeout_i(tgt_timeout_i));

// file: bench/bwaeh_tgt_model.sv
// Target bus slave model with delay and timeout modes
`timescale 1ns/1ps
module bwaeh_tgt_model (
	input  wire logic                     clk_i,
	input  wire logic                     rst_i,
	input  wire bwaeh_pkg::bwaeh_req_type req_i,
	input  wire logic [3:0]               dly_i,
	input  wire logic                     tmo_i,
	output logic                          ssyn_o,
	output logic                          tmo_o,
	output logic [15:0]                   rdata_o
);
	logic [15:0] mem [16];
	logic [3:0]  cnt;
	always_ff @(posedge clk_i) begin
		ssyn_o <= 1'h0;
		tmo_o <= 1'h0;
		rdata_o <= rst_i ? 16'h0000 : ~rdata_o;
		if (rst_i || !req_i.valid || ssyn_o || tmo_o) begin
			cnt <= 4'h0;
		end else if (cnt != dly_i) begin
			cnt <= cnt + 4'h1;
		end else if (tmo_i) begin
			tmo_o <= 1'h1;
		end else begin
			ssyn_o <= 1'h1;
			if (req_i.cyc[1])
				mem[req_i.addr[3:0]] <= req_i.wdata;
			else
				rdata_o <= mem[req_i.addr[3:0]];
		end
	end
endmodule // bwaeh_tgt_model

// file: bench/tb_top.sv
// Testbench of the window error handler
`timescale 1ns/1ps
`include "bwaeh_regs.svh"
module tb_top;
	logic                      clk_i = 1'h0;
	logic                      rst_i = 1'h1;
	logic                      stb = 1'h0;
	logic                      we = 1'h0;
	logic [7:0]                adr = 8'h00;
	logic [31:0]               dat = 32'h0;
	logic [31:0]               q;
	logic [31:0]               wb_dat_o;
	logic                      wb_ack_o;
	logic                      irq_o;
	logic                      ssyn;
	logic                      tmo;
	logic                      tm = 1'h0;
	logic                      rr = 1'h0;
	logic                      pl = 1'h0;
	logic [3:0]                dl = 4'h0;
	logic [15:0]               rdat;
	bwaeh_pkg::bwaeh_req_type  req = '0;
	bwaeh_pkg::bwaeh_req_type  tgt;
	bwaeh_pkg::bwaeh_resp_type resp;
	int                        failures = 0;
	int                        n_tests = 0;
	int                        wd = 0;
	always #12.5 clk_i = ~clk_i;
	bwaeh_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(stb), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .orig_req_i(req),
		.orig_resp_o(resp), .tgt_req_o(tgt), .tgt_ssyn_i(ssyn), .tgt_timeout_i(tmo), .tgt_rdata_i(rdat),
		.tgt_power_low_i(pl), .remote_read_i(rr), .irq_o(irq_o));
	bwaeh_tgt_model u_tgt (.clk_i(clk_i), .rst_i(rst_i), .req_i(tgt), .dly_i(dl), .tmo_i(tm),
		.ssyn_o(ssyn), .tmo_o(tmo), .rdata_o(rdat));
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do @(posedge clk_i); while (wb_ack_o !== 1'h1);
		q = wb_dat_o;
		stb <= 1'h0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wb(1'h1, a, d);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		wb(1'h0, a, 32'h0);
		chk($sformatf("reg %h", a), e, q);
	endtask
	task automatic orig(input logic [1:0] c, input logic [15:0] a, input logic s);
		int k;
		k = 0;
		req <= '{1'h1, bwaeh_pkg::bwaeh_cyc_type'(c), a, ~a};
		do begin
			@(posedge clk_i);
			k++;
		end while (resp.valid !== 1'h1 && k < 800);
		chk("sync", {30'h0, s, s & ~c[1]}, {30'h0, resp.valid, resp.drive});
		if (s && !c[1])
			chk("rdata", {16'h0, ~a}, {16'h0, resp.rdata});
		req.valid <= 1'h0;
		repeat (2) @(posedge clk_i);
		chk("release", 32'h0, {31'h0, resp.valid});
	endtask
	task automatic tcase(input logic [31:0] cs, input logic [1:0] c, input logic [15:0] a, input logic s,
		input logic [31:0] e);
		wr(`BWAEH_ADR_CSR, cs);
		orig(c, a, s);
		rchk(`BWAEH_ADR_CSR, e);
	endtask
	always @(posedge clk_i) begin
		wd <= wd + 1;
		if (wd == 20000) begin
			failures++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		rchk(`BWAEH_ADR_CSR, 32'h0);
		rchk(`BWAEH_ADR_INT_MASK, 32'h0);
		wr(8'h10, 32'hFFFF);
		rchk(8'h10, 32'h0);
		$display("Test reset done");
		for (int c = 0; c < 4; c++) begin
			wr(`BWAEH_ADR_CSR, 32'h84);
			tcase(32'h0, c[1:0], 16'h1, c[1], 32'h8000);
		end
		tcase(32'h0, 2'h2, 16'h2, 1'h0, 32'h8000);
		rchk(`BWAEH_ADR_DAR, 32'h0);
		rchk(`BWAEH_ADR_INT_STAT, 32'h1);
		chk("irq", 32'h0, {31'h0, irq_o});
		wr(`BWAEH_ADR_INT_MASK, 32'h1);
		chk("irq", 32'h1, {31'h0, irq_o});
		wr(`BWAEH_ADR_INT_STAT, 32'h1);
		chk("irq", 32'h0, {31'h0, irq_o});
		$display("Test closed done");
		dl <= 4'h3;
		tcase(32'h84, 2'h2, 16'h3, 1'h1, 32'h84);
		dl <= 4'h0;
		tcase(32'h84, 2'h3, 16'h4, 1'h1, 32'h84);
		tcase(32'h84, 2'h1, 16'h3, 1'h1, 32'h84);
		tcase(32'h80, 2'h1, 16'h3, 1'h0, 32'h8080);
		tcase(32'h80, 2'h2, 16'h3, 1'h1, 32'h8080);
		orig(2'h0, 16'h7, 1'h0);
		rchk(`BWAEH_ADR_DAR, 32'h3);
		rchk(`BWAEH_ADR_CSR, 32'h8080);
		tcase(32'h80, 2'h0, 16'h4, 1'h1, 32'h80);
		rchk(`BWAEH_ADR_DAR, 32'h4);
		$display("Test permit done");
		tm <= 1'h1;
		for (int c = 0; c < 4; c++)
			tcase(32'h84, c[1:0], 16'h5, c[1], 32'hC084);
		tm <= 1'h0;
		rr <= 1'h1;
		repeat (3) @(posedge clk_i);
		tcase(32'h84, 2'h0, 16'h6, 1'h0, 32'h8084);
		tcase(32'h84, 2'h1, 16'h6, 1'h0, 32'h8084);
		rr <= 1'h0;
		wr(`BWAEH_ADR_CSR, 32'h84);
		wr(`BWAEH_ADR_INT_STAT, 32'h7);
		pl <= 1'h1;
		repeat (4) @(posedge clk_i);
		pl <= 1'h0;
		repeat (4) @(posedge clk_i);
		rchk(`BWAEH_ADR_CSR, 32'h8084);
		rchk(`BWAEH_ADR_INT_STAT, 32'h4);
		$display("Test faults done");
		tally_and_finish();
	end
endmodule // tb_top
